/* File: logic/tsup_rc_sync.sv */
// Two-flop synchroniser and rising-edge detector for the low-speed RC clock.
// Assumes the RC clock is far slower than core_clk.
`timescale 1ns/1ps
module tsup_rc_sync (
   input  wire logic core_clk,   // Core clock
   input  wire logic srst,       // Synchronous reset
   input  wire logic rc_pin,     // Raw RC clock
   tsup_rc_if.src    rc          // Synchronised tick out
);
   logic meta;    // First stage, read only by the second
   logic sync;    // Second stage
   logic prev;    // Delayed copy for edge detection

   // Edge detection looks only at the second and third stages
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= rc_pin;
         sync <= meta;
         prev <= sync;
      end
   end

   assign rc.tick  = sync & ~prev;   // Rising RC edge
   assign rc.level = sync;
endmodule : tsup_rc_sync

/* File: logic/tsup_top.sv */
// Supervisor: 16-bit counter with bit-8 edge interrupt, watchdog, fast wake-up, LOW_VOLTAGE_RESET gate.
// Assumes pins and the RC clock are asynchronous; control bits come from core_clk logic.
//
// Contract
// - Rising edge: interrupt on bit 8 rising
// - Rising-edge interrupts spaced 512 counts apart
// - Restart: next interrupt at next bit-8 rise
// - Falling edge: interrupt on bit 8 falling
// - Threshold fixed at build time, 1.8-4.0 V
// - Threshold applies only after power-on completes
// - Disable bit stops low-voltage reset
// - Detection inactive in either halt state
// - Fast wake-up resumes after 45 RC periods
// - Watchdog period chosen by 2-bit field
// - Watchdog frozen while RC oscillator off
`timescale 1ns/1ps
module tsup_top #(
   parameter logic [2:0] LVR_LEVEL = tsup_pkg::LVR_LVL_DEF   // Build-time threshold code
) (
   input  wire logic        core_clk,          // 125 MHz core clock
   input  wire logic        srst,              // Synchronous reset, active high
   input  wire logic        low_speed_rc_clock,// Raw RC clock pin
   input  wire logic        count_run,         // Counter runs when high
   input  wire logic        count_restart,     // Pulse: counter back to zero
   input  wire logic        interrupt_edge_select, // 0 rising, 1 falling
   input  wire logic        irq_enable,        // Interrupt enable
   input  wire logic        irq_clear,         // Pulse: clear request flag
   input  wire logic        wdt_enable,        // Watchdog enable
   input  wire logic        wdt_clear,         // Pulse: restart watchdog
   input  wire logic [1:0]  wdt_period,        // Watchdog period field
   input  wire logic        rc_enable,         // RC oscillator enabled
   input  wire logic        por_done,          // Power-on sequence complete
   input  wire logic        lvr_disable,       // Aux control bit 2
   input  wire logic        halt_exe,          // Execution halt entered
   input  wire logic        halt_sys,          // System halt entered
   input  wire logic        wake_event,        // Async wake-up pin
   input  wire logic        fast_wake,         // Fast wake-up selected
   input  wire logic        vdd_low_pin,       // Async comparator: below threshold
   output logic [15:0]      count,             // Counter value
   output logic             irq_flag,          // Sticky request flag
   output logic             irq,               // Flag gated by enable
   output logic             resume,            // Pulse: leave halt
   output logic [2:0]       lvr_level,         // Threshold code to comparator
   output logic             lvr_armed,         // Detector active
   output logic             chip_reset         // Full chip reset request
);
   tsup_rc_if rc ();                           // Synchronised RC tick

   tsup_rc_sync u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .rc_pin   (low_speed_rc_clock),
      .rc       (rc.src)
   );

   // Pin synchronisers; first stage read only by second
   logic wake_m, wake_s;        // Wake pin stages
   logic vlow_m, vlow_s;        // Low-voltage pin stages
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_m <= 1'b0;
         wake_s <= 1'b0;
         vlow_m <= 1'b0;
         vlow_s <= 1'b0;
      end else begin
         wake_m <= wake_event;
         wake_s <= wake_m;
         vlow_m <= vdd_low_pin;
         vlow_s <= vlow_m;
      end
   end

   // ---- 16-bit counter and bit-8 edge ----
   logic [15:0] next_count;     // Counter next value
   logic        bit_now;        // Selected bit of next value
   logic        bit_old;        // Selected bit of current value
   logic        rise, fall;     // Edge detections
   logic        edge_hit;       // Selected edge seen

   // Restart loads zero; the edge test compares old and new bit, so a restart
   // drops bit 8 to 0 and the next rise comes only when counting reaches it again
   assign next_count = count_restart ? tsup_pkg::CNT_ZERO :
                       count_run     ? count + tsup_pkg::CNT_ONE : count;
   assign bit_now  = next_count[tsup_pkg::EDGE_BIT];
   assign bit_old  = count[tsup_pkg::EDGE_BIT];
   assign rise     = ~bit_old & bit_now;
   assign fall     = bit_old & ~bit_now & ~count_restart;
   assign edge_hit = interrupt_edge_select ? fall : rise;

   // Counter register
   always_ff @(posedge core_clk) begin
      if (srst) count <= tsup_pkg::CNT_ZERO;
      else count <= next_count;
   end

   // Sticky flag; a set in the clear cycle wins
   always_ff @(posedge core_clk) begin
      if (srst) irq_flag <= 1'b0;
      else if (edge_hit) irq_flag <= 1'b1;
      else if (irq_clear) irq_flag <= 1'b0;
   end

   assign irq = irq_flag & irq_enable;

   // ---- Power state and fast wake-up ----
   tsup_pkg::tsup_pwr_e pwr, next_pwr;   // Power state
   logic [5:0] wake_cnt;                 // RC periods since wake event
   logic [5:0] next_wake_cnt;
   logic       wake_done;                // 45 RC periods counted
   logic       halted;                   // Either halt requested

   logic       in_halt;                  // Halt requested or not yet resumed

   // The halt inputs may be short requests, so the detector gate also looks at
   // the power state: halt lasts from the request until the cycle of resume
   assign halted    = halt_exe | halt_sys;
   assign in_halt   = halted | (pwr != tsup_pkg::TSUP_RUN);
   assign wake_done = (wake_cnt == 6'(tsup_pkg::FAST_WAKE - 1)) & rc.tick;

   // State sequencing; slow wake is treated as immediate here
   always_comb begin
      next_pwr      = pwr;
      next_wake_cnt = wake_cnt;
      case (pwr)
         tsup_pkg::TSUP_RUN: begin
            if (halted) next_pwr = tsup_pkg::TSUP_HALT;
         end
         tsup_pkg::TSUP_HALT: begin
            next_wake_cnt = tsup_pkg::WAKE_ZERO;
            if (wake_s) next_pwr = fast_wake ? tsup_pkg::TSUP_WAKE : tsup_pkg::TSUP_RUN;
         end
         tsup_pkg::TSUP_WAKE: begin
            if (wake_done) next_pwr = tsup_pkg::TSUP_RUN;
            else if (rc.tick) next_wake_cnt = wake_cnt + tsup_pkg::WAKE_ONE;
         end
         default: next_pwr = tsup_pkg::TSUP_RUN;
      endcase
   end

   // Power state registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pwr      <= tsup_pkg::TSUP_RUN;
         wake_cnt <= tsup_pkg::WAKE_ZERO;
      end else begin
         pwr      <= next_pwr;
         wake_cnt <= next_wake_cnt;
      end
   end

   assign resume = (pwr != tsup_pkg::TSUP_RUN) & (next_pwr == tsup_pkg::TSUP_RUN);

   // ---- Watchdog ----
   // The watchdog counts synchronised RC ticks, not core cycles, so its period
   // does not depend on the core clock. The full count is wide enough for the
   // longest period; shorter periods compare against a smaller limit.
   // Limitation: a period change in mid-count takes effect at once, so a count
   // already past the new limit runs on until it wraps.
   logic [18:0] wd_cnt;          // RC periods since last clear
   logic [18:0] next_wd_cnt;
   logic [18:0] wd_limit;        // Selected period
   logic        wd_expire;       // Reached period

   assign wd_limit = (wdt_period == tsup_pkg::SEL_P0) ? tsup_pkg::WD_P0 :
                     (wdt_period == tsup_pkg::SEL_P1) ? tsup_pkg::WD_P1 :
                     (wdt_period == tsup_pkg::SEL_P2) ? tsup_pkg::WD_P2 :
                                                        tsup_pkg::WD_P3;
   // Counting needs a live oscillator; with it off no tick ever advances the count
   assign wd_expire   = wdt_enable & rc_enable & rc.tick
                        & (wd_cnt == wd_limit - tsup_pkg::WD_ONE);
   assign next_wd_cnt = (wdt_clear | ~wdt_enable | wd_expire) ? tsup_pkg::WD_ZERO :
                        (rc_enable & rc.tick) ? wd_cnt + tsup_pkg::WD_ONE : wd_cnt;

   // Watchdog register and reset request
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wd_cnt     <= tsup_pkg::WD_ZERO;
         chip_reset <= 1'b0;
      end else begin
         wd_cnt     <= next_wd_cnt;
         chip_reset <= wd_expire | (lvr_armed & vlow_s);
      end
   end

   // ---- Low-voltage reset gating ----
   // The comparator pin is only trusted once power-on has finished; before that
   // the supply ramp would look like a low-voltage event and reset the chip
   // again. The gate is registered so that a short glitch on the control bits
   // cannot arm the detector for part of a cycle.
   // Threshold is a parameter only; no port can change it
   assign lvr_level = LVR_LEVEL;
   logic lvr_on;                // Detector enable, registered
   always_ff @(posedge core_clk) begin
      if (srst) lvr_on <= 1'b0;
      else lvr_on <= por_done & ~lvr_disable & ~in_halt;
   end
   assign lvr_armed = lvr_on & ~in_halt;

   // ---- Checks ----
   // Each check watches outputs or internal state of this block; inputs appear
   // as the cause side of an implication, except por_done and lvr_disable,
   // which a_lvr_after_por and a_lvr_disable_bit sample with $past after it.
   a_rise_sets_flag: assert property (@(posedge core_clk) disable iff (srst)
      (!interrupt_edge_select && !count[8] && count_run && !count_restart
       && count[7:0] == 8'hff) |=> irq_flag)
      else $error("Flag not set on bit 8 rise");
   a_fall_sets_flag: assert property (@(posedge core_clk) disable iff (srst)
      (interrupt_edge_select && count[8] && count_run && !count_restart
       && count[7:0] == 8'hff) |=> irq_flag)
      else $error("Flag not set on bit 8 fall");
   a_set_wins_clear: assert property (@(posedge core_clk) disable iff (srst)
      (edge_hit && irq_clear) |=> irq_flag)
      else $error("Set lost to clear");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (srst)
      (irq_flag && !irq_clear) |=> irq_flag)
      else $error("Flag dropped without clear");
   a_restart_edge: assert property (@(posedge core_clk) disable iff (srst)
      count_restart |=> (count == 16'h0000))
      else $error("Restart did not zero counter");
   a_lvr_gate: assert property (@(posedge core_clk) disable iff (srst)
      (!por_done || lvr_disable) |=> !lvr_armed)
      else $error("Detector armed while disabled");
   a_halt_quiet: assert property (@(posedge core_clk) disable iff (srst)
      (halt_exe || halt_sys) |-> !lvr_armed)
      else $error("Detector armed in halt");
   a_wd_frozen: assert property (@(posedge core_clk) disable iff (srst)
      (!rc_enable && !wdt_clear && wdt_enable) |=> $stable(wd_cnt))
      else $error("Watchdog moved with RC off");
   a_wd_reset: assert property (@(posedge core_clk) disable iff (srst)
      wd_expire |=> chip_reset)
      else $error("No reset on expiry");
   a_wake_count: assert property (@(posedge core_clk) disable iff (srst)
      (pwr == tsup_pkg::TSUP_WAKE && !wake_done) |-> !resume)
      else $error("Resumed before 45 RC periods");

   // Fast wake leaves only on the last counted RC period
   a_wake_last: assert property (@(posedge core_clk) disable iff (srst)
      (pwr == tsup_pkg::TSUP_WAKE && resume) |-> (wake_cnt == 6'h2c))
      else $error("Fast wake ended at wrong count");
   // Slow wake resumes in the cycle the wake pin is seen
   a_slow_wake: assert property (@(posedge core_clk) disable iff (srst)
      (pwr == tsup_pkg::TSUP_HALT && wake_s && !fast_wake) |-> resume)
      else $error("Slow wake did not resume");
   // Interrupt output never without the sticky flag
   a_irq_gate: assert property (@(posedge core_clk) disable iff (srst)
      irq |-> irq_flag)
      else $error("Interrupt without flag");
   // A restart never raises the flag on its own
   a_restart_quiet: assert property (@(posedge core_clk) disable iff (srst)
      (count_restart && !irq_flag) |=> !irq_flag)
      else $error("Restart raised the flag");
   // No rising interrupt away from the bit 8 carry
   a_no_early_rise: assert property (@(posedge core_clk) disable iff (srst)
      (!interrupt_edge_select && count_run && !count_restart && !irq_flag
       && count[7:0] != 8'hff) |=> !irq_flag)
      else $error("Flag set between bit 8 rises");
   // A disabled watchdog holds its count at zero
   a_wd_disabled: assert property (@(posedge core_clk) disable iff (srst)
      !wdt_enable |=> (wd_cnt == tsup_pkg::WD_ZERO))
      else $error("Disabled watchdog counted");
   // A clear restarts the count
   a_wd_clear: assert property (@(posedge core_clk) disable iff (srst)
      wdt_clear |=> (wd_cnt == tsup_pkg::WD_ZERO))
      else $error("Watchdog clear ignored");
   // Period field code 3 to longest limit mapping
   a_wd_limit: assert property (@(posedge core_clk) disable iff (srst)
      (wdt_period == 2'h3) |-> (wd_limit == 19'h40000))
      else $error("Longest period wrong");
   // Threshold code is the build-time value
   a_lvr_level: assert property (@(posedge core_clk) disable iff (srst)
      lvr_level == LVR_LEVEL)
      else $error("Threshold code changed");
   // Detector armed only after power-on completed
   a_lvr_after_por: assert property (@(posedge core_clk) disable iff (srst)
      lvr_armed |-> $past(por_done))
      else $error("Detector armed before power-on");
   // Detector armed only when the disable bit was low
   a_lvr_disable_bit: assert property (@(posedge core_clk) disable iff (srst)
      lvr_armed |-> !$past(lvr_disable))
      else $error("Detector armed while disable bit set");
   // Detector quiet for the whole halt state
   a_halt_state_quiet: assert property (@(posedge core_clk) disable iff (srst)
      (pwr != tsup_pkg::TSUP_RUN) |-> !lvr_armed)
      else $error("Detector armed in halt state");
   // Chip reset only from expiry or an armed low-voltage event
   a_reset_source: assert property (@(posedge core_clk) disable iff (srst)
      chip_reset |-> ($past(wd_expire) || ($past(lvr_armed) && $past(vlow_s))))
      else $error("Chip reset without cause");
endmodule : tsup_top

/* File: shared/tsup_pkg.sv */
// Constants and types for the 16-bit counter, watchdog and low-voltage-reset supervisor.
// Assumes one core clock and a low-speed RC clock that arrives as an ordinary input.
package tsup_pkg;
   localparam int unsigned CNT_W      = 16;         // Counter width
   localparam int unsigned EDGE_BIT   = 8;          // Counter bit that raises the interrupt
   localparam logic [15:0] CNT_ZERO   = 16'h0000;   // Counter restart value
   localparam logic [15:0] CNT_ONE    = 16'h0001;   // Counter step
   localparam int unsigned FAST_WAKE  = 45;         // Fast wake-up, in RC periods
   localparam int unsigned WD_W       = 19;         // Watchdog counter width
   localparam logic [18:0] WD_P0      = 19'h02000;  // 8192 RC periods
   localparam logic [18:0] WD_P1      = 19'h04000;  // 16384 RC periods
   localparam logic [18:0] WD_P2      = 19'h10000;  // 65536 RC periods
   localparam logic [18:0] WD_P3      = 19'h40000;  // 262144 RC periods
   localparam logic [18:0] WD_ONE     = 19'h00001;  // Watchdog step
   localparam logic [18:0] WD_ZERO    = 19'h00000;  // Watchdog restart value
   localparam logic [1:0]  SEL_P0     = 2'h0;       // Period field codes
   localparam logic [1:0]  SEL_P1     = 2'h1;
   localparam logic [1:0]  SEL_P2     = 2'h2;
   localparam logic [5:0]  WAKE_ZERO  = 6'h00;      // Wake counter restart
   localparam logic [5:0]  WAKE_ONE   = 6'h01;      // Wake counter step
   localparam int unsigned LVR_LVL_W  = 3;          // Build-time threshold code width
   localparam logic [2:0]  LVR_LVL_DEF = 3'h7;      // Default code, 1.8 V
   typedef enum logic [1:0] {TSUP_RUN, TSUP_HALT, TSUP_WAKE} tsup_pwr_e;
endpackage : tsup_pkg

/* File: shared/tsup_rc_if.sv */
// Carries the synchronised low-speed RC tick between the top and its synchroniser.
// Assumes a single core clock drives both ends.
`timescale 1ns/1ps
interface tsup_rc_if;
   logic tick;    // One-cycle pulse on each rising RC edge
   logic level;   // Synchronised RC level
   modport src (output tick, output level);
   modport dst (input tick, input level);
endinterface : tsup_rc_if

/* File: tb/tsup_tb.sv */
// Self-checking bench for the supervisor: counter interrupt, watchdog, wake-up, LOW_VOLTAGE_RESET gate.
// Assumes the design top drives its outputs from core_clk; the RC clock runs free here.
`timescale 1ns/1ps
module tb;
   logic        core_clk = 1'b0;  // Core clock, 8 ns period
   logic        srst     = 1'b1;  // Synchronous reset
   logic        rc_clk   = 1'b0;  // RC clock, 8 core periods so the watchdog run stays short
   logic        run = 1'b0, restart = 1'b0, edge_sel = 1'b0, irq_en = 1'b0, irq_clr = 1'b0;
   logic        wdt_en = 1'b0, wdt_clr = 1'b0, rc_en = 1'b1, por = 1'b0, lvr_dis = 1'b0;
   logic        h_exe = 1'b0, h_sys = 1'b0, wake = 1'b0, fast = 1'b0, vdd_low = 1'b0;
   logic [1:0]  period = 2'h0;    // Watchdog period field
   logic [15:0] count;            // Counter value
   logic        irq_flag, irq, resume, lvr_armed, chip_reset;
   logic [2:0]  lvr_level;        // Threshold code
   int          n_errors = 0;     // Mismatch count
   int          checks   = 0;     // Comparison count
   int          rc_cnt   = 0;     // RC rises seen while the oscillator is enabled
   int          i;                // Loop index for bounded waits

   tsup_top DUT (.core_clk(core_clk), .srst(srst), .low_speed_rc_clock(rc_clk),
      .count_run(run), .count_restart(restart), .interrupt_edge_select(edge_sel),
      .irq_enable(irq_en), .irq_clear(irq_clr), .wdt_enable(wdt_en), .wdt_clear(wdt_clr),
      .wdt_period(period), .rc_enable(rc_en), .por_done(por), .lvr_disable(lvr_dis),
      .halt_exe(h_exe), .halt_sys(h_sys), .wake_event(wake), .fast_wake(fast),
      .vdd_low_pin(vdd_low), .count(count), .irq_flag(irq_flag), .irq(irq),
      .resume(resume), .lvr_level(lvr_level), .lvr_armed(lvr_armed), .chip_reset(chip_reset));

   // Clocks: core free running, RC unrelated in phase
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      #13;
      forever #32 rc_clk = ~rc_clk;
   end
   // Reference tick count, frozen like the watchdog when the oscillator is off
   always @(posedge rc_clk) begin
      if (rc_en) rc_cnt++;
   end

   // Inputs change 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   // A wait that used up its bound ends the run
   task automatic timed_out(input string what);
      n_errors++;
      $display("unexpected %s: expected event, seen timeout", what);
      end_of_test();
   endtask : timed_out
   task automatic wait_flag();
      for (i = 0; i < 2000 && irq_flag !== 1'b1; i++) step(1);
      if (irq_flag !== 1'b1) timed_out("irq_flag");
   endtask : wait_flag
   task automatic clear_flag();
      irq_clr = 1'b1;
      step(1);
      irq_clr = 1'b0;
      step(1);
   endtask : clear_flag

   // Rising edge from zero: 0x100 then 0x300; flag sticky without enable
   task automatic t_rising();
      edge_sel = 1'b0;
      restart = 1'b1;
      run = 1'b1;
      step(1);
      restart = 1'b0;
      wait_flag();
      chk("first rise count", 16'h0100, count);
      chk("irq while disabled", 16'h0000, {15'h0000, irq});
      step(20);
      chk("flag stays set", 16'h0001, {15'h0000, irq_flag});
      irq_en = 1'b1;
      step(1);
      chk("irq enabled", 16'h0001, {15'h0000, irq});
      clear_flag();
      chk("flag cleared", 16'h0000, {15'h0000, irq_flag});
      wait_flag();
      chk("second rise count", 16'h0300, count);
      clear_flag();
   endtask : t_rising

   // Restart mid-period, then falling edge selection
   task automatic t_restart_fall();
      step(100);
      restart = 1'b1;
      step(1);
      restart = 1'b0;
      clear_flag();
      wait_flag();
      chk("rise after restart", 16'h0100, count);
      edge_sel = 1'b1;
      clear_flag();
      wait_flag();
      chk("first fall count", 16'h0200, count);
      clear_flag();
      wait_flag();
      chk("second fall count", 16'h0400, count);
      run = 1'b0;
      clear_flag();
   endtask : t_restart_fall

   // Threshold code, arming after power-on, disable bit, both halt states, fast wake
   task automatic t_lvr_wake();
      int t0;
      logic ok;
      chk("lvr_level", 16'h0007, {13'h0000, lvr_level});
      vdd_low = 1'b1;
      step(10);
      chk("armed before por", 16'h0000, {15'h0000, lvr_armed});
      chk("reset before por", 16'h0000, {15'h0000, chip_reset});
      vdd_low = 1'b0;
      step(3);
      por = 1'b1;
      step(3);
      chk("armed after por", 16'h0001, {15'h0000, lvr_armed});
      chk("reset after por", 16'h0000, {15'h0000, chip_reset});
      lvr_dis = 1'b1;
      step(3);
      chk("armed when disabled", 16'h0000, {15'h0000, lvr_armed});
      lvr_dis = 1'b0;
      fast = 1'b1;
      for (int k = 0; k < 2; k++) begin
         h_exe = (k == 0);
         h_sys = (k == 1);
         step(3);
         h_exe = 1'b0;
         h_sys = 1'b0;
         chk("armed in halt", 16'h0000, {15'h0000, lvr_armed});
         wake = 1'b1;
         t0 = rc_cnt;
         for (i = 0; i < 1000 && resume !== 1'b1; i++) step(1);
         if (resume !== 1'b1) timed_out("resume");
         wake = 1'b0;
         ok = (rc_cnt - t0 >= 44 && rc_cnt - t0 <= 46);
         chk("fast wake ticks", 16'h0001, {15'h0000, ok});
         step(3);
      end
   endtask : t_lvr_wake

   // Watchdog expiry at 8192 ticks, frozen meanwhile by the oscillator enable
   task automatic t_watchdog();
      int t0;
      logic ok;
      period = 2'h0;
      wdt_en = 1'b1;
      wdt_clr = 1'b1;
      step(1);
      wdt_clr = 1'b0;
      t0 = rc_cnt;
      step(20000);
      rc_en = 1'b0;
      step(3000);
      rc_en = 1'b1;
      for (i = 0; i < 60000 && chip_reset !== 1'b1; i++) step(1);
      if (chip_reset !== 1'b1) timed_out("chip_reset");
      ok = (rc_cnt - t0 >= 8191 && rc_cnt - t0 <= 8194);
      chk("watchdog ticks", 16'h0001, {15'h0000, ok});
      step(1);
      chk("reset pulse width", 16'h0000, {15'h0000, chip_reset});
   endtask : t_watchdog

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      step(10);
      srst = 1'b0;
      step(2);
      t_rising();
      t_restart_fall();
      t_lvr_wake();
      t_watchdog();
      end_of_test();
   end
endmodule : tb
